/* hdl/soc_pkg.sv */
package soc_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] ADDR_CFG_A = 8'h1F;
  localparam logic [7:0] ADDR_CFG_B = 8'h20;
  localparam logic [7:0] ADDR_CFG_C = 8'h21;
  localparam logic [7:0] ADDR_STAT_LO = 8'h30;
  localparam logic [7:0] ADDR_STAT_HI = 8'h31;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int OUT1_LSB = 0;
  localparam int OUT2_LSB = 3;
  localparam int OUT3_LO_LSB = 6;
  localparam int OUT3_MSB_BIT = 0;
  localparam int OUT4_LSB = 1;
  localparam int OUT5_LSB = 4;
  localparam int OUT6_LSB_BIT = 7;
  localparam int OUT6_HI_LSB = 0;
  localparam int OUT7_LSB = 2;
  localparam int OUT8_LSB = 4;
  localparam int OUT9_LSB = 6;

  // ****************************************
  // Counts
  // ****************************************
  localparam int NUM_OUT = 9;
  localparam int SMALL_OUTS = 8;
  localparam int TRACK_OUTS = 4;
  localparam int CPUMP_OUTS = 6;

  typedef enum logic [2:0] {
    MODE_OD_LOW = 3'b000,
    MODE_OD_HIGH = 3'b001,
    MODE_PP_LOW = 3'b010,
    MODE_PP_HIGH = 3'b011,
    MODE_TRACK = 3'b100,
    MODE_CPUMP = 3'b101
  } soc_mode_type;

  typedef struct packed {
    logic [NUM_OUT-1:0] out;
    logic [NUM_OUT-1:0] oe;
    logic [NUM_OUT-1:0] track;
    logic [NUM_OUT-1:0] cpump;
  } soc_drive_type;

endpackage

/* hdl/soc_output_config.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module soc_output_config
  import soc_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [NUM_OUT-1:0] i_slot_assert,
  output logic [7:0] o_rdata,
  output logic [NUM_OUT-1:0] o_pin_out,
  output logic [NUM_OUT-1:0] o_pin_oe,
  output logic [TRACK_OUTS-1:0] o_track_en,
  output logic [CPUMP_OUTS-1:0] o_cpump_en,
  output logic o_cfg_bad
);

  // ****************************************
  // Configuration registers
  // ****************************************
  logic [7:0] cfg_a;
  logic [7:0] cfg_b;
  logic [7:0] cfg_c;
  soc_drive_type drv;
  soc_drive_type next_drv;
  logic bad;
  logic next_bad;
  logic [2:0] field [NUM_OUT];
  logic [7:0] next_rdata;

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cfg_a <= CFG_RESET;
      cfg_b <= CFG_RESET;
      cfg_c <= CFG_RESET;
    end else if (i_wr) begin
      if (i_addr == ADDR_CFG_A) begin
        cfg_a <= i_wdata;
      end
      if (i_addr == ADDR_CFG_B) begin
        cfg_b <= i_wdata;
      end
      if (i_addr == ADDR_CFG_C) begin
        cfg_c <= i_wdata;
      end
    end
  end

  // ****************************************
  // Field assembly
  // ****************************************
  // Two fields straddle register boundaries
  always_comb begin
    field[0] = cfg_a[OUT1_LSB +: 3];
    field[1] = cfg_a[OUT2_LSB +: 3];
    field[2] = {cfg_b[OUT3_MSB_BIT], cfg_a[OUT3_LO_LSB +: 2]};
    field[3] = cfg_b[OUT4_LSB +: 3];
    field[4] = cfg_b[OUT5_LSB +: 3];
    field[5] = {cfg_c[OUT6_HI_LSB +: 2], cfg_b[OUT6_LSB_BIT]};
    field[6] = {1'b0, cfg_c[OUT7_LSB +: 2]};
    field[7] = {1'b0, cfg_c[OUT8_LSB +: 2]};
    field[8] = {1'b0, cfg_c[OUT9_LSB +: 2]};
  end

  // ****************************************
  // Mode decode
  // ****************************************
  // Reserved codes leave the pin released rather than guess a drive
  always_comb begin
    next_drv = '0;
    next_bad = 1'b0;
    for (int k = 0; k < NUM_OUT; k++) begin
      case (soc_mode_type'(field[k]))
        MODE_OD_LOW: begin
          next_drv.oe[k] = i_slot_assert[k];
        end
        MODE_OD_HIGH: begin
          next_drv.oe[k] = ~i_slot_assert[k];
        end
        MODE_PP_LOW: begin
          next_drv.oe[k] = 1'b1;
          next_drv.out[k] = ~i_slot_assert[k];
        end
        MODE_PP_HIGH: begin
          next_drv.oe[k] = 1'b1;
          next_drv.out[k] = i_slot_assert[k];
        end
        MODE_TRACK: begin
          if (k < TRACK_OUTS) begin
            next_drv.track[k] = i_slot_assert[k];
          end else begin
            next_bad = 1'b1;
          end
        end
        MODE_CPUMP: begin
          if (k < CPUMP_OUTS) begin
            next_drv.cpump[k] = i_slot_assert[k];
          end else begin
            next_bad = 1'b1;
          end
        end
        default: begin
          next_bad = 1'b1;
        end
      endcase
      if (!LARGE_VARIANT && k >= SMALL_OUTS) begin
        next_drv.oe[k] = 1'b0;
        next_drv.out[k] = 1'b0;
      end
    end
  end

  // Pins stay high impedance through reset, like power-up
  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      drv <= '0;
      bad <= 1'b0;
    end else begin
      drv <= next_drv;
      bad <= next_bad;
    end
  end

  assign o_pin_out = drv.out;
  assign o_pin_oe = drv.oe;
  assign o_track_en = drv.track[TRACK_OUTS-1:0];
  assign o_cpump_en = drv.cpump[CPUMP_OUTS-1:0];
  assign o_cfg_bad = bad;

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    next_rdata = 8'h00;
    if (i_rd) begin
      case (i_addr)
        ADDR_CFG_A: next_rdata = cfg_a;
        ADDR_CFG_B: next_rdata = cfg_b;
        ADDR_CFG_C: next_rdata = cfg_c;
        ADDR_STAT_LO: next_rdata = drv.oe[7:0];
        ADDR_STAT_HI: next_rdata = {6'h00, bad, drv.oe[8]};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  od_low_assert_a: assert property (
    cfg_a[2:0] == 3'h0 && i_slot_assert[0] |=> o_pin_oe[0] && !o_pin_out[0])
    else $error("output 1 open-drain low not pulled low");

  track_four_a: assert property (
    cfg_b[3:1] == 3'h4 |=> o_track_en[3] == $past(i_slot_assert[3])
      && !o_pin_oe[3])
    else $error("output 4 tracking enable wrong");

  cpump_six_a: assert property (
    {cfg_c[1:0], cfg_b[7]} == 3'h5 && i_slot_assert[5]
      |=> o_cpump_en[5] && !o_cfg_bad)
    else $error("output 6 charge pump not enabled");

  out2_field_a: assert property (
    cfg_a[5:3] == 3'h3 |=> o_pin_oe[1]
      && o_pin_out[1] == $past(i_slot_assert[1]))
    else $error("output 2 push-pull high wrong");

  out3_split_a: assert property (
    {cfg_b[0], cfg_a[7:6]} == 3'h2 |=> o_pin_oe[2]
      && o_pin_out[2] != $past(i_slot_assert[2]))
    else $error("output 3 push-pull low wrong");

  out5_field_a: assert property (
    cfg_b[6:4] == 3'h4 |=> o_cfg_bad && !o_pin_oe[4])
    else $error("output 5 reserved code not flagged");

  out6_split_a: assert property (
    {cfg_c[1:0], cfg_b[7]} == 3'h1 && !i_slot_assert[5]
      |=> o_pin_oe[5] && !o_pin_out[5])
    else $error("output 6 open-drain high idle not low");

  out8_two_bit_a: assert property (
    cfg_c[5:4] == 2'h1 && i_slot_assert[7] |=> !o_pin_oe[7])
    else $error("output 8 open-drain high not released");

  od_never_high_a: assert property (
    cfg_a[2:1] == 2'h0 |=> !o_pin_out[0])
    else $error("open-drain output driven high");

  slot_gate_a: assert property (
    !i_slot_assert[0] |=> !o_track_en[0] && !o_cpump_en[0])
    else $error("output 1 asserted outside its slot");

  if (!LARGE_VARIANT) begin : g_small
    small_nine_a: assert property (
      ##1 !o_pin_oe[8])
      else $error("output 9 active on small variant");
    small_eight_a: assert property (
      cfg_c[5:4] == 2'h3 |=> o_pin_oe[7])
      else $error("output 8 lost on small variant");
  end

  read_back_a: assert property (
    i_rd && i_addr == ADDR_CFG_B |=> o_rdata == $past(cfg_b))
    else $error("config readback mismatch");

  cfg_a_write_a: assert property (
    i_wr && i_addr == ADDR_CFG_A |=> cfg_a == $past(i_wdata))
    else $error("config a write lost");

  cfg_c_write_a: assert property (
    i_wr && i_addr == ADDR_CFG_C |=> cfg_c == $past(i_wdata))
    else $error("config c write lost");

  unmapped_read_a: assert property (
    i_rd && i_addr == 8'h22 |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");

  rdata_idle_a: assert property (
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data outside its cycle");

  stat_hi_read_a: assert property (
    i_rd && i_addr == ADDR_STAT_HI |=> o_rdata
      == {6'h00, $past(o_cfg_bad), $past(o_pin_oe[8])})
    else $error("status readback mismatch");

  out1_reserved_a: assert property (
    cfg_a[2:1] == 2'h3 |=> o_cfg_bad && !o_pin_oe[0])
    else $error("output 1 reserved code not refused");

  od_high_release_a: assert property (
    cfg_a[5:3] == 3'h1 && i_slot_assert[1] |=> !o_pin_oe[1])
    else $error("output 2 open-drain high not released");

  od_slot_gate_a: assert property (
    cfg_a[5:3] == 3'h0 && !i_slot_assert[1] |=> !o_pin_oe[1])
    else $error("output 2 pulled low outside its slot");

  track_no_pin_a: assert property (
    cfg_a[2:0] == 3'h4 |=> !o_pin_oe[0] && !o_cpump_en[0]
      && o_track_en[0] == $past(i_slot_assert[0]))
    else $error("output 1 tracking drive wrong");

  cpump_no_pin_a: assert property (
    cfg_a[2:0] == 3'h5 |=> !o_pin_oe[0] && !o_track_en[0]
      && o_cpump_en[0] == $past(i_slot_assert[0]))
    else $error("output 1 charge pump drive wrong");

  pp_both_levels_a: assert property (
    cfg_b[3:1] == 3'h3 |=> o_pin_oe[3]
      && o_pin_out[3] == $past(i_slot_assert[3]))
    else $error("output 4 push-pull high wrong");

  pp_low_idle_a: assert property (
    cfg_b[6:4] == 3'h2 && !i_slot_assert[4] |=> o_pin_oe[4]
      && o_pin_out[4])
    else $error("output 5 push-pull low idle not high");

  out7_field_a: assert property (
    cfg_c[3:2] == 2'h2 |=> o_pin_oe[6]
      && o_pin_out[6] != $past(i_slot_assert[6]))
    else $error("output 7 push-pull low wrong");

  out9_field_a: assert property (
    LARGE_VARIANT && cfg_c[7:6] == 2'h3 |=> o_pin_oe[8]
      && o_pin_out[8] == $past(i_slot_assert[8]))
    else $error("output 9 push-pull high wrong");

  cov_od_c: cover property (o_pin_oe[0] && !o_pin_out[0]);
  cov_track_c: cover property (o_track_en[0] ##1 !o_track_en[0]);
  cov_cpump_c: cover property (o_cpump_en[5]);
  cov_pp_c: cover property (o_pin_oe[2] && o_pin_out[2]);
  cov_bad_c: cover property (o_cfg_bad);

endmodule

`default_nettype wire

/* tb/soc_supply_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Pin levels with pull-ups
// ****
module soc_supply_model
  import soc_pkg::*;
(
  input wire logic [NUM_OUT-1:0] i_pin_out,
  input wire logic [NUM_OUT-1:0] i_pin_oe,
  output logic [NUM_OUT-1:0] o_level
);
  // Released pin reads the pull-up, never its last value
  assign o_level = (i_pin_oe & i_pin_out) | ~i_pin_oe;
endmodule
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
  import soc_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [8:0] i_slot_assert = 9'h000;
  logic [7:0] o_rdata;
  logic [8:0] o_pin_out, o_pin_oe, lvl, small_oe;
  logic [3:0] o_track_en;
  logic [5:0] o_cpump_en;
  logic o_cfg_bad;
  int err_total = 0;
  int samples_checked = 0;
  int cycles = 0;
  soc_output_config DUT (.i_sys_clk, .i_resetn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_slot_assert, .o_rdata, .o_pin_out, .o_pin_oe,
    .o_track_en, .o_cpump_en, .o_cfg_bad);
  // Small variant sees the same traffic
  soc_output_config #(.LARGE_VARIANT(1'b0)) small_dut (.i_sys_clk,
    .i_resetn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_slot_assert,
    .o_rdata(), .o_pin_out(), .o_pin_oe(small_oe), .o_track_en(),
    .o_cpump_en(), .o_cfg_bad());
  soc_supply_model far_side (.i_pin_out(o_pin_out),
    .i_pin_oe(o_pin_oe), .o_level(lvl));
  initial begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge i_sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_total++;
      $display("BAD %0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [8:0] g, input logic [8:0] e,
    input string m);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("BAD %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_sys_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk({1'b0, o_rdata}, {1'b0, e}, "rd");
  endtask
  // ****
  // Program all fields, then judge pins
  // ****
  task automatic apply(input logic [8:0][2:0] cd, input logic [8:0] s,
    input logic [3:0] etr, input logic [5:0] ecp, input logic ebad);
    logic [23:0] v;
    logic [8:0] eo, ev, el;
    for (int k = 0; k < 9; k++) begin
      if (k < 6) v[3*k+:3] = cd[k];
      else v[18+2*(k-6)+:2] = cd[k][1:0];
      case (cd[k])
        3'h0: {eo[k], ev[k], el[k]} = {s[k], 1'b0, ~s[k]};
        3'h1: {eo[k], ev[k], el[k]} = {~s[k], 1'b0, s[k]};
        3'h2: {eo[k], ev[k], el[k]} = {1'b1, ~s[k], ~s[k]};
        3'h3: {eo[k], ev[k], el[k]} = {1'b1, s[k], s[k]};
        default: {eo[k], ev[k], el[k]} = 3'h1;
      endcase
    end
    wr(ADDR_CFG_A, v[7:0]);
    wr(ADDR_CFG_B, v[15:8]);
    wr(ADDR_CFG_C, v[23:16]);
    i_slot_assert <= s;
    repeat (3) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
    chk(o_pin_oe, eo, "oe");
    chk(o_pin_out, ev, "out");
    chk(lvl, el, "wire");
    chk(9'(o_track_en), 9'(etr), "trk");
    chk(9'(o_cpump_en), 9'(ecp), "cp");
    chk(9'(o_cfg_bad), 9'(ebad), "bad");
    chk(small_oe, {1'b0, eo[7:0]}, "small");
    rd(ADDR_CFG_A, v[7:0]);
    rd(ADDR_CFG_B, v[15:8]);
    rd(ADDR_CFG_C, v[23:16]);
    rd(ADDR_STAT_LO, eo[7:0]);
    rd(ADDR_STAT_HI, {6'h00, ebad, eo[8]});
  endtask
  task automatic t_reset();
    rd(ADDR_CFG_A, CFG_RESET);
    rd(ADDR_CFG_B, CFG_RESET);
    rd(8'h22, 8'h00);
    chk(o_pin_oe, 9'h000, "rst");
    $display("test reset done");
  endtask
  task automatic t_decode();
    logic [8:0][2:0] cd;
    for (int c = 0; c < 4; c++) begin
      for (int k = 0; k < 9; k++) cd[k] = 3'((c + k) % 4);
      apply(cd, 9'h0B5, 4'h0, 6'h00, 1'b0);
      apply(cd, 9'h14A, 4'h0, 6'h00, 1'b0);
    end
    $display("test decode done");
  endtask
  task automatic t_special();
    logic [8:0][2:0] cd;
    cd = {3'h3, 3'h2, 3'h1, 3'h5, 3'h5, 3'h4, 3'h4, 3'h4, 3'h4};
    apply(cd, 9'h1FF, 4'hF, 6'h30, 1'b0);
    apply(cd, 9'h0A5, 4'h5, 6'h20, 1'b0);
    cd = {15'h0, 3'h5, 3'h5, 3'h5, 3'h5};
    apply(cd, 9'h00B, 4'h0, 6'h0B, 1'b0);
    $display("test special done");
  endtask
  task automatic t_refuse();
    logic [8:0][2:0] cd;
    cd = '0;
    cd[4] = 3'h4;
    apply(cd, 9'h1FF, 4'h0, 6'h00, 1'b1);
    cd = '0;
    cd[0] = 3'h6;
    cd[5] = 3'h7;
    apply(cd, 9'h1FF, 4'h0, 6'h00, 1'b1);
    $display("test refuse done");
  endtask
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    t_reset();
    t_decode();
    t_special();
    t_refuse();
    complete_run();
  end
endmodule
`default_nettype wire
